// ---- design/dws_synth.sv ----
// Phase accumulator waveform synthesizer core
// What this block does
// (RL1) Samples are unsigned 12-bit codes
// (RL2) Waveform length runs from 8 to 16000
// (RL3) Each location is one equal phase step
// (RL4) Add phase step every clock, no counter; here only on clocks with ce high, the run state and FIFO room
// (RL5) Phase accumulator is 48 bits wide
// (RL6) Upper 14 accumulator bits form the address
// (RL7) New step acts next cycle, phase continuous
// (RL8) Large steps skip memory locations
// (RL9) Small steps repeat the previous sample
// (RL10) Every sample shown only at low rates
// (RL11) One fixed 40 MHz sample clock
// (RL12) Sine picks sharp filter, others linear-phase
// (RL13) Built-in shapes hold 16000 samples
// (RL14) Built-in shapes span all converter codes
// (RL15) Record replays endlessly, last wraps first
// (RL16) Loader should use full length, codes
// (RL17) Accumulator wraps; address scaled to length
// (RL18) One sample per clock to converter
`timescale 1ns/1ps
module dws_synth (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [47:0] phase_step_constant,
  input wire logic step_load,
  input wire logic [2:0] func_sel,
  input wire logic func_load,
  input wire logic [13:0] user_len,
  input wire logic len_load,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [13:0] wr_addr,
  input wire logic [11:0] wr_data,
  output logic [11:0] dac_data,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic filt_sharp,
  output logic fill_busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dws_pkg::dws_state_type st_q;
  dws_pkg::dws_func_type func_q;
  logic [47:0] acc_q;
  logic [47:0] psc_q;
  logic [13:0] user_len_q;
  logic [13:0] len_q;
  logic [13:0] fill_idx_q;
  logic [13:0] addr_q;
  logic [27:0] addr_prod;
  logic v1_q;
  logic v2_q;
  logic run;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_take;
  logic [11:0] fifo_out_data;
  logic filt_sharp_q;
  logic [11:0] dac_data_q;
  logic dac_valid_q;
  logic func_ok;

  dws_mem_if mem_bus ();

  // ----------------------------------------------------------------
  // Built-in shape generator
  // ----------------------------------------------------------------
  // Shapes are computed per index so no large constant table is needed
  function automatic logic [11:0] shape_calc(input dws_pkg::dws_func_type f, input logic [13:0] i);
    logic [29:0] p;
    logic [11:0] r;
    logic [10:0] u;
    logic [21:0] pq;
    logic [10:0] q;
    begin
      p = {16'h0000, i} * {14'h0000, dws_pkg::RAMP_K};
      r = p[27:16];
      u = r[10:0];
      pq = {11'h000, u} * {11'h000, 11'h7FF - u};
      q = pq[19:9] + {10'h000, pq[19]};
      case (f)
        dws_pkg::FN_SINE: begin
          shape_calc = r[11] ? (12'h7FF - {1'b0, q}) : (12'h800 + {1'b0, q}); // [RL14]
        end
        dws_pkg::FN_SQUARE: begin
          shape_calc = r[11] ? 12'h000 : 12'hFFF; // [RL14]
        end
        dws_pkg::FN_TRIANGLE: begin
          shape_calc = r[11] ? ~{u, u[10]} : {u, u[10]}; // [RL14]
        end
        dws_pkg::FN_RAMP: begin
          shape_calc = r; // [RL14]
        end
        default: begin
          shape_calc = r;
        end
      endcase
    end
  endfunction : shape_calc

  // ----------------------------------------------------------------
  // Function select and fill sequencer
  // ----------------------------------------------------------------
  assign func_ok = (func_sel <= 3'h4);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      func_q <= dws_pkg::FN_SINE;
      filt_sharp_q <= 1'b1;
    end else if (ce && func_load && func_ok) begin
      func_q <= dws_pkg::dws_func_type'(func_sel);
      filt_sharp_q <= (func_sel == dws_pkg::FN_SINE); // [RL12]
    end
  end

  // Reset starts in the fill state so the memory holds a sine at once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= dws_pkg::ST_FILL;
    end else if (ce) begin
      case (st_q)
        dws_pkg::ST_RUN: begin
          if (func_load && func_ok && func_sel != dws_pkg::FN_USER) begin
            st_q <= dws_pkg::ST_FILL; // [RL13]
          end
        end
        dws_pkg::ST_FILL: begin
          if (func_load && func_sel == dws_pkg::FN_USER) begin
            st_q <= dws_pkg::ST_RUN;
          end else if (!(func_load && func_ok) && fill_idx_q == dws_pkg::BUILTIN_LEN - 14'h0001) begin
            st_q <= dws_pkg::ST_RUN; // [RL13]
          end
        end
        default: begin
          st_q <= dws_pkg::ST_FILL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fill_idx_q <= dws_pkg::IDX_RST;
    end else if (ce && func_load && func_ok) begin
      fill_idx_q <= dws_pkg::IDX_RST;
    end else if (ce && st_q == dws_pkg::ST_FILL) begin
      fill_idx_q <= fill_idx_q + 14'h0001; // [RL13]
    end
  end

  // ----------------------------------------------------------------
  // Waveform length
  // ----------------------------------------------------------------
  // Out-of-range lengths are clamped rather than refused
  always_ff @(posedge clk) begin
    if (!nrst) begin
      user_len_q <= dws_pkg::LEN_MAX;
    end else if (ce && len_load) begin
      if (user_len < dws_pkg::LEN_MIN) begin
        user_len_q <= dws_pkg::LEN_MIN; // [RL2]
      end else if (user_len > dws_pkg::LEN_MAX) begin
        user_len_q <= dws_pkg::LEN_MAX; // [RL2]
      end else begin
        user_len_q <= user_len;
      end
    end
  end

  assign len_q = (func_q == dws_pkg::FN_USER) ? user_len_q : dws_pkg::BUILTIN_LEN; // [RL13]

  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  // The pipeline stalls on a full FIFO rather than dropping samples
  assign run = ce && (st_q == dws_pkg::ST_RUN) && fifo_in_ready; // [RL11] [RL18]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      psc_q <= dws_pkg::PSC_RST;
    end else if (ce && step_load) begin
      psc_q <= phase_step_constant; // [RL7]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= dws_pkg::ACC_RST;
    end else if (run) begin
      acc_q <= acc_q + psc_q; // [RL4] [RL5] [RL17]
    end
  end

  // ----------------------------------------------------------------
  // Address scaling and memory read
  // ----------------------------------------------------------------
  // Top 14 bits scaled onto the length give 0 .. length-1 and wrap cleanly
  assign addr_prod = {14'h0000, acc_q[47:34]} * {14'h0000, len_q}; // [RL6] [RL3] [RL17]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q <= 14'h0000;
    end else if (run) begin
      addr_q <= addr_prod[27:14]; // [RL8] [RL9] [RL10] [RL15]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end else if (ce && st_q == dws_pkg::ST_FILL) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end else if (run) begin
      v1_q <= 1'b1;
      v2_q <= v1_q;
    end
  end

  // Fill writes have priority; user writes only in the run state
  assign wr_ready = (st_q == dws_pkg::ST_RUN);
  assign mem_bus.we = ce && ((st_q == dws_pkg::ST_FILL) || wr_valid);
  assign mem_bus.waddr = (st_q == dws_pkg::ST_FILL) ? fill_idx_q : wr_addr;
  assign mem_bus.wdata = (st_q == dws_pkg::ST_FILL) ? shape_calc(func_q, fill_idx_q) : wr_data; // [RL1]
  assign mem_bus.re = run;
  assign mem_bus.raddr = addr_q;

  dws_wave_mem u_mem (
    .clk(clk),
    .port(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // Output FIFO and converter register
  // ----------------------------------------------------------------
  dws_fifo #(
    .WIDTH(dws_pkg::SAMP_W),
    .DEPTH(dws_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(v2_q && st_q == dws_pkg::ST_RUN),
    .in_ready(fifo_in_ready),
    .in_data(mem_bus.rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );

  assign fifo_take = !dac_valid_q || dac_ready;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dac_data_q <= dws_pkg::DAC_RST;
      dac_valid_q <= 1'b0;
    end else if (ce && fifo_take) begin
      dac_valid_q <= fifo_out_valid; // [RL18]
      if (fifo_out_valid) begin
        dac_data_q <= fifo_out_data; // [RL1]
      end
    end
  end

  assign dac_data = dac_data_q;
  assign dac_valid = dac_valid_q;
  assign filt_sharp = filt_sharp_q;
  assign fill_busy = (st_q == dws_pkg::ST_FILL);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  acc_add_a: assert property (run |=> acc_q == $past(acc_q) + $past(psc_q)) // [RL4]
    else $error("accumulator did not add the step");

  step_take_a: assert property ((ce && step_load) ##1 run |=> // [RL7]
    acc_q == $past(acc_q) + $past(phase_step_constant, 2))
    else $error("new step not used on the following cycle");

  acc_hold_a: assert property (!run |=> $stable(acc_q)) // [RL7]
    else $error("accumulator moved while stalled");

  addr_scale_a: assert property (run |=> // [RL6]
    addr_q == 14'((28'($past(acc_q[47:34])) * 28'($past(len_q))) >> 14))
    else $error("address not scaled from upper phase bits");

  addr_range_a: assert property (v1_q |-> addr_q < len_q) // [RL17]
    else $error("address beyond waveform length");

  len_range_a: assert property (len_q >= dws_pkg::LEN_MIN && len_q <= dws_pkg::LEN_MAX) // [RL2]
    else $error("waveform length out of range");

  filt_path_a: assert property (filt_sharp == (func_q == dws_pkg::FN_SINE)) // [RL12]
    else $error("filter path does not follow function");

  fill_end_a: assert property ((ce && st_q == dws_pkg::ST_FILL && !func_load // [RL13]
    && fill_idx_q == dws_pkg::BUILTIN_LEN - 14'h0001) |=> st_q == dws_pkg::ST_RUN)
    else $error("fill did not end after the last sample");

  fill_span_a: assert property ((st_q == dws_pkg::ST_FILL && func_q == dws_pkg::FN_SQUARE // [RL14]
    && fill_idx_q == 14'h0000) |-> mem_bus.wdata == 12'hFFF)
    else $error("square does not reach full scale");

  out_hold_a: assert property ((dac_valid && !dac_ready) |=> $stable(dac_data)) // [RL18]
    else $error("converter sample changed while held");

  fill_run_c: cover property (st_q == dws_pkg::ST_FILL ##1 st_q == dws_pkg::ST_RUN);
  user_func_c: cover property (ce && func_load && func_sel == dws_pkg::FN_USER);
  wrap_c: cover property (run ##1 addr_q == 14'h0000 ##1 addr_q == 14'h0000);
  stall_c: cover property (st_q == dws_pkg::ST_RUN && !fifo_in_ready);

endmodule : dws_synth

// ---- shared/dws_pkg.sv ----
// Shared constants and types for the waveform synthesizer
package dws_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ACC_W = 48;
  localparam int ADDR_W = 14;
  localparam int SAMP_W = 12;
  localparam int MEM_DEPTH = 16384;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_HZ = 32'h02625A00;

  // ----------------------------------------------------------------
  // Waveform lengths and shape scaling
  // ----------------------------------------------------------------
  localparam logic [13:0] LEN_MIN = 14'h0008;
  localparam logic [13:0] LEN_MAX = 14'h3E80;
  localparam logic [13:0] BUILTIN_LEN = 14'h3E80;
  localparam logic [15:0] RAMP_K = 16'h4189;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [47:0] ACC_RST = 48'h0;
  localparam logic [47:0] PSC_RST = 48'h0;
  localparam logic [13:0] IDX_RST = 14'h0000;
  localparam logic [11:0] DAC_RST = 12'h800;

  // ----------------------------------------------------------------
  // Functions and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_SINE = 3'h0,
    FN_SQUARE = 3'h1,
    FN_TRIANGLE = 3'h2,
    FN_RAMP = 3'h3,
    FN_USER = 3'h4
  } dws_func_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_FILL = 2'h2
  } dws_state_type;

endpackage : dws_pkg

// ---- shared/dws_mem_if.sv ----
// Write and read port of the waveform memory
`timescale 1ns/1ps
interface dws_mem_if;
  logic we;
  logic [13:0] waddr;
  logic [11:0] wdata;
  logic re;
  logic [13:0] raddr;
  logic [11:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : dws_mem_if

// ---- design/dws_wave_mem.sv ----
// Waveform sample memory with registered read
`timescale 1ns/1ps
module dws_wave_mem (
  input wire logic clk,
  dws_mem_if.mem port
);
  logic [11:0] ram [0:dws_pkg::MEM_DEPTH-1];

  always_ff @(posedge clk) begin
    if (port.we) begin
      ram[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (port.re) begin
      port.rdata <= ram[port.raddr];
    end
  end
endmodule : dws_wave_mem

// ---- design/dws_fifo.sv ----
// Small sample FIFO between the memory read and the converter
`timescale 1ns/1ps
module dws_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + CW'(1);
    end else if (pop && !push) begin
      count_q <= count_q - CW'(1);
    end
  end

  fifo_count_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && push && !pop) |=> count_q == $past(count_q) + CW'(1))
    else $error("fifo count did not rise on push");
endmodule : dws_fifo

// ---- bench/dws_dac_model.sv ----
// Converter-side model that takes or refuses samples
`timescale 1ns/1ps
module dws_dac_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic dac_valid,
  input wire logic [11:0] dac_data,
  output logic dac_ready
);
  logic [11:0] last_q;
  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // Mode 0 always takes, 1 at random, 2 refuses so the FIFO backs up
  initial dac_ready = 1'b1;
  always @(posedge clk) begin
    case (mode)
      2'h0: dac_ready <= 1'b1;
      2'h1: dac_ready <= ($urandom % 3) != 0;
      default: dac_ready <= 1'b0;
    endcase
  end
  // One sample taken per clock at most
  always @(posedge clk) begin
    if (dac_valid && dac_ready) last_q <= dac_data;
  end
endmodule : dws_dac_model

// ---- bench/dws_synth_tb.sv ----
// Self-checking bench for the waveform synthesizer core
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dws_synth_tb;
  typedef struct { logic [47:0] acc; bit sw; } dws_hyp_type;
  logic clk, nrst, ce, step_load, func_load, len_load, wr_valid, wr_ready;
  logic dac_valid, dac_ready, filt_sharp, fill_busy;
  logic [47:0] psc;
  logic [2:0] func_sel;
  logic [13:0] user_len, wr_addr;
  logic [11:0] wr_data, dac_data;
  logic [1:0] dac_mode;
  int errors, n_checks, cyc, len_m, mn, mx, cnt, f;
  bit track, sweep, rnd_ce, pend, exp_sh;
  logic [47:0] cur_m, new_m;
  logic [11:0] mem_m [16384];
  dws_hyp_type hq[$];

  dws_synth i_dut (.clk(clk), .nrst(nrst), .ce(ce), .phase_step_constant(psc), .step_load(step_load),
    .func_sel(func_sel), .func_load(func_load), .user_len(user_len), .len_load(len_load),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready), .filt_sharp(filt_sharp),
    .fill_busy(fill_busy));
  dws_dac_model i_dac (.clk(clk), .mode(dac_mode), .dac_valid(dac_valid), .dac_data(dac_data),
    .dac_ready(dac_ready));

  // ----------------------------------------------------------------
  // Clock, enable and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) ce <= rnd_ce ? (($urandom % 8) != 0) : 1'b1;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      errors++;
      $display("timeout");
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic int adr(input logic [47:0] a);
    return (int'(a[47:34]) * len_m) >> 14;
  endfunction : adr

  // Keeps every phase history still consistent with the samples, since
  // the exact cycle a new step reaches the converter is hidden by the FIFO
  task automatic chk_sample();
    dws_hyp_type nq[$];
    dws_hyp_type h;
    logic [11:0] exp;
    bit all_sw;
    exp = mem_m[adr(hq[0].acc + (hq[0].sw ? new_m : cur_m))];
    foreach (hq[i]) begin
      h = hq[i];
      if (!h.sw && mem_m[adr(h.acc + cur_m)] === dac_data) nq.push_back('{h.acc + cur_m, 1'b0});
      if ((h.sw || pend) && mem_m[adr(h.acc + new_m)] === dac_data) nq.push_back('{h.acc + new_m, 1'b1});
    end
    if (nq.size() == 0) nq.push_back('{hq[0].acc + cur_m, 1'b0});
    else exp = mem_m[adr(nq[0].acc)];
    `CHK(dac_data, exp)
    hq = nq;
    all_sw = 1'b1;
    foreach (hq[i]) all_sw &= hq[i].sw;
    if (pend && all_sw) begin
      cur_m = new_m;
      pend = 1'b0;
      foreach (hq[i]) hq[i].sw = 1'b0;
    end
  endtask : chk_sample

  always @(posedge clk) begin
    if (nrst && ce && dac_valid && dac_ready) begin
      if (sweep && dac_data < mn) mn = int'(dac_data);
      if (sweep && dac_data > mx) mx = int'(dac_data);
      if (track) chk_sample();
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Kind 0 step, 1 function, 2 length; enable is forced high for the load
  task automatic load(input int kind, input logic [47:0] v);
    rnd_ce = 1'b0;
    repeat (2) @(posedge clk);
    step_load <= (kind == 0);
    func_load <= (kind == 1);
    len_load <= (kind == 2);
    psc <= v;
    func_sel <= v[2:0];
    user_len <= v[13:0];
    @(posedge clk);
    step_load <= 1'b0;
    func_load <= 1'b0;
    len_load <= 1'b0;
    if (kind == 0) begin
      new_m = v;
      pend = 1'b1;
    end
    if (kind == 2) len_m = (v < 8) ? 8 : ((v > 16000) ? 16000 : int'(v));
    rnd_ce = track;
  endtask : load

  task automatic wr(input int i, input logic [11:0] d);
    wr_valid <= 1'b1;
    wr_addr <= i[13:0];
    wr_data <= d;
    do @(posedge clk); while (wr_ready !== 1'b1);
    mem_m[i] = d;
  endtask : wr

  // Second reset, user record written, then two step changes under stalls
  task automatic run_user(input int len, input logic [47:0] sa, input logic [47:0] sb);
    int i;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    load(1, 48'h4);
    for (i = 0; i < ((len < 8) ? 8 : len); i++) wr(i, 12'(i * 37 + 5));
    wr_valid <= 1'b0;
    load(2, 48'(len));
    load(0, 48'h0);
    cur_m = 48'h0;
    pend = 1'b0;
    hq = '{'{48'h0, 1'b0}};
    repeat (20) @(posedge clk);
    track = 1'b1;
    dac_mode <= 2'h1;
    load(0, sa);
    repeat (1500) @(posedge clk);
    dac_mode <= 2'h2;
    repeat (12) @(posedge clk);
    `CHK(dac_valid, 1'b1)
    dac_mode <= 2'h1;
    load(0, sb);
    repeat (1500) @(posedge clk);
    track = 1'b0;
    rnd_ce = 1'b0;
    dac_mode <= 2'h0;
    $display("test user len %0d done", len);
  endtask : run_user

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {errors, n_checks, cyc, cnt} = '0;
    {nrst, step_load, func_load, len_load, wr_valid} = 5'h00;
    {psc, func_sel, user_len, wr_addr, wr_data, dac_mode} = '0;
    {track, sweep, rnd_ce, pend, exp_sh} = '0;
    mn = 4095;
    mx = 0;
    len_m = 16000;
    void'($urandom(32'h294e));
    repeat (3) @(posedge clk);
    #1;
    `CHK({dac_data, dac_valid, filt_sharp, fill_busy, wr_ready}, 16'h8006)
    repeat (13) @(posedge clk);
    nrst <= 1'b1;
    while (fill_busy === 1'b1 && cnt < 16100) begin
      @(posedge clk);
      cnt++;
    end
    `CHK(cnt >= 15990 && cnt <= 16010, 1'b1)
    $display("test reset and fill done");
    load(0, 48'h0004_0000_0000);
    repeat (10) @(posedge clk);
    sweep = 1'b1;
    repeat (16500) @(posedge clk);
    sweep = 1'b0;
    `CHK({12'(mn), 12'(mx)}, 24'h000FFF)
    $display("test builtin sweep done");
    for (f = 0; f < 6; f++) begin
      load(1, 48'(f));
      repeat (2) @(posedge clk);
      #1;
      if (f < 5) exp_sh = (f == 0);
      `CHK({filt_sharp, fill_busy, wr_ready}, {exp_sh, 1'(f < 4), 1'(f >= 4)})
      load(1, 48'h4);
    end
    $display("test function select done");
    run_user(4000, 48'({$urandom, $urandom} | 64'h8000_0000_0000), 48'({$urandom, $urandom} >> 4));
    run_user(3, 48'hE000_0000_0000, 48'h0100_0000_0000);
    report_and_stop();
  end
endmodule : dws_synth_tb
